// ### verilog/tcic_top.sv
/*
 * Register bank for group timing, automatic and forced recalibration, and interrupt enables
 * of a fourteen-input capacitive touch controller, with the recalibration sequencers it steers.
 * Assumes the serial bus protocol engine, the sensing front end and the status registers all run
 * on sys_clk_i, so none of their signals is synchronised here.
 */
`timescale 1ns/1ps

module tcic_top #(
    parameter int unsigned CYCLES_PER_MS = tcic_pkg::CLK_PER_MS
) (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port from the serial bus protocol engine.
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Sensing front end.
    input wire logic [tcic_pkg::BUTTONS-1:0] sample_en_i,
    input wire logic [tcic_pkg::CHANNELS-1:0] touch_raw_i,
    input wire logic [tcic_pkg::CHANNELS-1:0] drift_recal_req_i,
    input wire logic slide_active_i,
    input wire logic [1:0] slide_speed_i,
    // Status bits kept elsewhere.
    input wire logic group_event_status_i,
    input wire logic [tcic_pkg::BUTTONS-1:0] sensor_status_i,
    input wire logic [7:0] gpio_status_i,
    // Calibration and touch results.
    output logic [tcic_pkg::CHANNELS-1:0] touch_valid_o,
    output logic [tcic_pkg::CHANNELS-1:0] base_invalid_o,
    output logic [tcic_pkg::CHANNELS-1:0] analog_cal_o,
    output logic [tcic_pkg::CHANNELS-1:0] digital_cal_o,
    output logic slide_repeat_tick_o,
    output logic irq_o
);

    // All state of this module in one record.
    typedef struct packed {
        logic [7:0] group_timing;
        logic [7:0] auto_recal;
        logic [7:0] force_buttons;
        logic [7:0] irq_sensors;
        logic [7:0] irq_gpio;
        logic [7:0] force_grouped;
        logic [6:0] group_done;
        logic [17:0] presc;
        logic ms_tick;
        logic [13:0] press_ms;
        logic press_fired;
        logic group_timeout;
        logic [9:0] slide_ms;
        logic slide_tick;
        logic irq;
        logic [7:0] rdata;
    } tcic_state_type;

    tcic_state_type s_q; // Registered state.
    tcic_state_type s_d; // Next state.

    localparam logic [17:0] PRESC_LAST = 18'(CYCLES_PER_MS - 1); // Last prescaler count.

    logic [tcic_pkg::CHANNELS-1:0] start; // Per-channel recalibration request.
    logic [tcic_pkg::CHANNELS-1:0] busy; // Per-channel recalibration in progress.
    logic [tcic_pkg::CHANNELS-1:0] done; // Per-channel successful completion pulse.
    logic [tcic_pkg::CHANNELS-1:0] forced; // Forced request bits in channel order.
    logic [tcic_pkg::CHANNELS-1:0] auto_req; // Automatic requests after gating.
    logic group_auto_recal_on; // Group automatic recalibration enable.
    logic group_force_recal; // Group forced recalibration bit.
    logic [13:0] press_limit; // Decoded longest grouped press.
    logic [9:0] slide_repeat_interval; // Base repeat interval in milliseconds.
    logic [9:0] slide_interval; // Interval after speed adjustment.
    tcic_pkg::tcic_status_type status; // Status bits gathered for the interrupt.
    tcic_pkg::tcic_status_type status_en; // Matching enable bits.

    // Decode the control fields and form the per-channel requests.
    always_comb begin
        group_auto_recal_on = s_q.auto_recal[tcic_pkg::GROUP_BIT];
        group_force_recal = s_q.force_buttons[tcic_pkg::GROUP_BIT];
        press_limit = tcic_pkg::max_press_ms(
            s_q.group_timing[tcic_pkg::MAX_PRESS_LSB +: tcic_pkg::FIELD_W]);
        slide_repeat_interval = 10'(({6'h00, s_q.group_timing[tcic_pkg::REPEAT_LSB +: tcic_pkg::FIELD_W]}
            + 10'h001) * tcic_pkg::REPEAT_STEP_MS);
        // A faster slide halves the interval per speed step, never below one millisecond.
        slide_interval = slide_repeat_interval >> slide_speed_i;
        if (slide_interval == 10'h000) begin
            slide_interval = 10'h001;
        end
        // Buttons: own enable, and only while the input is sampled at all.
        auto_req[tcic_pkg::BUTTONS-1:0] = drift_recal_req_i[tcic_pkg::BUTTONS-1:0]
            & s_q.auto_recal[tcic_pkg::BUTTONS-1:0] & sample_en_i;
        // Grouped channels recalibrate together on a press timeout, each alone on its own drift request, and only under the group enable.
        auto_req[tcic_pkg::CHANNELS-1:tcic_pkg::BUTTONS] = group_auto_recal_on
            ? ({tcic_pkg::BUTTONS{s_q.group_timeout}} | drift_recal_req_i[tcic_pkg::CHANNELS-1:tcic_pkg::BUTTONS])
            : '0;
        forced[tcic_pkg::BUTTONS-1:0] = s_q.force_buttons[tcic_pkg::BUTTONS-1:0];
        forced[tcic_pkg::CHANNELS-1:tcic_pkg::BUTTONS] = s_q.force_grouped[tcic_pkg::BUTTONS-1:0]
            | ({tcic_pkg::BUTTONS{group_force_recal}} & ~s_q.group_done);
        // Done masks a stale request for one cycle.
        start = (forced | auto_req) & ~done;
        status = '{group_event: group_event_status_i, sensor: sensor_status_i, gpio: gpio_status_i};
        status_en = '{group_event: s_q.irq_sensors[tcic_pkg::GROUP_BIT],
            sensor: s_q.irq_sensors[tcic_pkg::BUTTONS-1:0], gpio: s_q.irq_gpio};
    end

    // One sequencer per channel.
    genvar ch;
    generate
        for (ch = 0; ch < tcic_pkg::CHANNELS; ch++) begin : g_chan
            tcic_recal_seq u_seq (
                .sys_clk_i(sys_clk_i),
                .sys_rst_i(sys_rst_i),
                .ce_i(ce_i),
                .ms_tick_i(s_q.ms_tick),
                .start_i(start[ch]),
                .touch_i(touch_raw_i[ch]),
                .busy_o(busy[ch]),
                .analog_o(analog_cal_o[ch]),
                .digital_o(digital_cal_o[ch]),
                .done_o(done[ch])
            );
        end
    endgenerate

    // Next-state logic: time base, timers, register writes, self-clearing and read data.
    always_comb begin
        s_d = s_q;
        // Millisecond prescaler keeps every long time a small count.
        s_d.ms_tick = 1'b0;
        if (s_q.presc == PRESC_LAST) begin
            s_d.presc = 18'h00000;
            s_d.ms_tick = 1'b1;
        end else begin
            s_d.presc = s_q.presc + 18'h00001;
        end
        // Longest press on the group: fire once, then wait for release.
        s_d.group_timeout = 1'b0;
        if (~|touch_raw_i[tcic_pkg::CHANNELS-1:tcic_pkg::BUTTONS]) begin
            s_d.press_ms = 14'h0000;
            s_d.press_fired = 1'b0;
        end else if (s_q.ms_tick && !s_q.press_fired) begin
            s_d.press_ms = s_q.press_ms + 14'h0001;
            if (s_q.press_ms + 14'h0001 >= press_limit) begin
                s_d.group_timeout = 1'b1;
                s_d.press_fired = 1'b1;
            end
        end
        // Slide repeat pulses while a slide lasts.
        s_d.slide_tick = 1'b0;
        if (!slide_active_i) begin
            s_d.slide_ms = 10'h000;
        end else if (s_q.ms_tick) begin
            if (s_q.slide_ms + 10'h001 >= slide_interval) begin
                s_d.slide_ms = 10'h000;
                s_d.slide_tick = 1'b1;
            end else begin
                s_d.slide_ms = s_q.slide_ms + 10'h001;
            end
        end
        // Hardware clears come first so a host write in the same cycle wins.
        s_d.force_buttons[tcic_pkg::BUTTONS-1:0] = s_q.force_buttons[tcic_pkg::BUTTONS-1:0]
            & ~done[tcic_pkg::BUTTONS-1:0];
        s_d.force_grouped[tcic_pkg::BUTTONS-1:0] = s_q.force_grouped[tcic_pkg::BUTTONS-1:0]
            & ~done[tcic_pkg::CHANNELS-1:tcic_pkg::BUTTONS];
        // Collect grouped successes while the group bit is set; clear it when all are in.
        if (group_force_recal) begin
            s_d.group_done = s_q.group_done | done[tcic_pkg::CHANNELS-1:tcic_pkg::BUTTONS];
            if (&s_d.group_done) begin
                s_d.force_buttons[tcic_pkg::GROUP_BIT] = 1'b0;
                s_d.group_done = 7'h00;
            end
        end else begin
            s_d.group_done = 7'h00;
        end
        // Host writes.
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                tcic_pkg::ADDR_GROUP_TIMING: s_d.group_timing = reg_wdata_i;
                tcic_pkg::ADDR_AUTO_RECAL: s_d.auto_recal = reg_wdata_i;
                tcic_pkg::ADDR_FORCE_BUTTONS: begin
                    s_d.force_buttons = reg_wdata_i;
                    // A new group request starts a fresh success collection.
                    s_d.group_done = 7'h00;
                end
                tcic_pkg::ADDR_IRQ_SENSORS: s_d.irq_sensors = reg_wdata_i;
                tcic_pkg::ADDR_IRQ_GPIO: s_d.irq_gpio = reg_wdata_i;
                tcic_pkg::ADDR_FORCE_GROUPED: s_d.force_grouped = reg_wdata_i & tcic_pkg::GROUPED_USED_MASK;
                default: begin
                    // Writes to other offsets belong to other blocks.
                end
            endcase
        end
        // Enabled status bits drive the interrupt; disabled ones are ignored.
        s_d.irq = |(status & status_en);
        // Registered read data; unmapped offsets read as zero.
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                tcic_pkg::ADDR_GROUP_TIMING: s_d.rdata = s_q.group_timing;
                tcic_pkg::ADDR_AUTO_RECAL: s_d.rdata = s_q.auto_recal;
                tcic_pkg::ADDR_FORCE_BUTTONS: s_d.rdata = s_q.force_buttons;
                tcic_pkg::ADDR_IRQ_SENSORS: s_d.rdata = s_q.irq_sensors;
                tcic_pkg::ADDR_IRQ_GPIO: s_d.rdata = s_q.irq_gpio;
                tcic_pkg::ADDR_FORCE_GROUPED: s_d.rdata = s_q.force_grouped;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    // Register the state; the clock enable freezes everything.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '{group_timing: tcic_pkg::RST_GROUP_TIMING, auto_recal: tcic_pkg::RST_AUTO_RECAL,
                     force_buttons: tcic_pkg::RST_FORCE_BUTTONS, irq_sensors: tcic_pkg::RST_IRQ_SENSORS,
                     irq_gpio: tcic_pkg::RST_IRQ_GPIO, force_grouped: tcic_pkg::RST_FORCE_GROUPED,
                     group_done: 7'h00, presc: 18'h00000, ms_tick: 1'b0, press_ms: 14'h0000,
                     press_fired: 1'b0, group_timeout: 1'b0, slide_ms: 10'h000, slide_tick: 1'b0,
                     irq: 1'b0, rdata: 8'h00};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // A recalibrating sensor hides its presses and flags its base count invalid.
    assign touch_valid_o = touch_raw_i & ~busy;
    assign base_invalid_o = busy;
    assign slide_repeat_tick_o = s_q.slide_tick;
    assign irq_o = s_q.irq;
    assign reg_rdata_o = s_q.rdata;

endmodule // tcic_top

// ### verilog/tcic_pkg.sv
/*
 * Shared constants, types and decode functions of the touch calibration and interrupt control block.
 * Assumes a single 200 MHz device clock and a register port driven by the serial bus protocol engine.
 */
package tcic_pkg;

    // Register offsets on the device register port.
    localparam logic [7:0] ADDR_GROUP_TIMING = 8'h24;
    localparam logic [7:0] ADDR_AUTO_RECAL = 8'h25;
    localparam logic [7:0] ADDR_FORCE_BUTTONS = 8'h26;
    localparam logic [7:0] ADDR_IRQ_SENSORS = 8'h27;
    localparam logic [7:0] ADDR_IRQ_GPIO = 8'h28;
    localparam logic [7:0] ADDR_FORCE_GROUPED = 8'h46;

    // Reset values of the registers.
    localparam logic [7:0] RST_GROUP_TIMING = 8'hd4;
    localparam logic [7:0] RST_AUTO_RECAL = 8'hff;
    localparam logic [7:0] RST_FORCE_BUTTONS = 8'h00;
    localparam logic [7:0] RST_IRQ_SENSORS = 8'hff;
    localparam logic [7:0] RST_IRQ_GPIO = 8'h00;
    localparam logic [7:0] RST_FORCE_GROUPED = 8'h00;

    // Field positions.
    localparam int GROUP_BIT = 7;
    localparam int MAX_PRESS_LSB = 4;
    localparam int REPEAT_LSB = 0;
    localparam int FIELD_W = 4;
    localparam logic [7:0] GROUPED_USED_MASK = 8'h7f;

    // Channel counts: inputs 1 to 7 are buttons, 8 to 14 form the group.
    localparam int BUTTONS = 7;
    localparam int CHANNELS = 14;

    // Clock rate and the millisecond time base derived from it.
    localparam int CLK_KHZ = 200000;
    localparam int CLK_PER_MS = CLK_KHZ;

    // Recalibration phases in milliseconds; together they fill the 600 ms blind window.
    localparam int RECAL_MAX_MS = 600;
    localparam logic [9:0] ANALOG_MS = 10'h064;
    localparam logic [9:0] DIGITAL_MS = 10'(RECAL_MAX_MS) - ANALOG_MS;

    // Step of the repeat interval code in milliseconds.
    localparam logic [9:0] REPEAT_STEP_MS = 10'h023;

    // Phases of one channel's recalibration sequencer.
    typedef enum logic [1:0] {
        RC_IDLE,
        RC_ANALOG,
        RC_DIGITAL
    } tcic_recal_phase_type;

    // State of one channel's recalibration sequencer.
    typedef struct packed {
        tcic_recal_phase_type phase;
        logic [9:0] ms_cnt;
        logic done;
    } tcic_recal_state_type;

    // Register read or write request from the bus protocol engine.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tcic_reg_req_type;

    // Status bits that may raise the interrupt.
    typedef struct packed {
        logic group_event;
        logic [BUTTONS-1:0] sensor;
        logic [7:0] gpio;
    } tcic_status_type;

    // Longest press on a grouped sensor, in milliseconds, per 4-bit code.
    function automatic logic [13:0] max_press_ms(input logic [3:0] code);
        logic [13:0] ms;
        ms = 14'h0000;
        unique case (code)
            4'h0: ms = 14'h0230;
            4'h1: ms = 14'h0348;
            4'h2: ms = 14'h0460;
            4'h3: ms = 14'h0578;
            4'h4: ms = 14'h0690;
            4'h5: ms = 14'h08c0;
            4'h6: ms = 14'h0af0;
            4'h7: ms = 14'h0d20;
            4'h8: ms = 14'h0f50;
            4'h9: ms = 14'h1180;
            4'ha: ms = 14'h15e0;
            4'hb: ms = 14'h1a40;
            4'hc: ms = 14'h1ea0;
            4'hd: ms = 14'h22ca;
            4'he: ms = 14'h2760;
            4'hf: ms = 14'h2bc0;
        endcase
        return ms;
    endfunction

endpackage

// ### verilog/tcic_recal_seq.sv
/*
 * One channel's recalibration sequencer: analog trim phase followed by base count capture.
 * Assumes a one-cycle millisecond tick and a touch level from logic on the same clock.
 */
`timescale 1ns/1ps
module tcic_recal_seq (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Time base and control.
    input wire logic ms_tick_i,
    input wire logic start_i,
    input wire logic touch_i,
    // Sequencer state.
    output logic busy_o,
    output logic analog_o,
    output logic digital_o,
    output logic done_o
);

    tcic_pkg::tcic_recal_state_type s_q; // Registered sequencer state.
    tcic_pkg::tcic_recal_state_type s_d; // Next sequencer state.

    // Step the phases on millisecond ticks; a touch aborts the run without a done pulse.
    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        unique case (s_q.phase)
            tcic_pkg::RC_IDLE: begin
                // Start only from idle so a running calibration is never restarted midway.
                if (start_i) begin
                    s_d.phase = tcic_pkg::RC_ANALOG;
                    s_d.ms_cnt = 10'h000;
                end
            end
            tcic_pkg::RC_ANALOG: begin
                if (touch_i) begin
                    s_d.phase = tcic_pkg::RC_IDLE;
                end else if (ms_tick_i) begin
                    s_d.ms_cnt = s_q.ms_cnt + 10'h001;
                    if (s_q.ms_cnt == tcic_pkg::ANALOG_MS - 10'h001) begin
                        s_d.phase = tcic_pkg::RC_DIGITAL;
                        s_d.ms_cnt = 10'h000;
                    end
                end
            end
            tcic_pkg::RC_DIGITAL: begin
                if (touch_i) begin
                    s_d.phase = tcic_pkg::RC_IDLE;
                end else if (ms_tick_i) begin
                    s_d.ms_cnt = s_q.ms_cnt + 10'h001;
                    if (s_q.ms_cnt == tcic_pkg::DIGITAL_MS - 10'h001) begin
                        s_d.phase = tcic_pkg::RC_IDLE;
                        s_d.done = 1'b1;
                    end
                end
            end
        endcase
    end

    // Register the state; the clock enable freezes everything.
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_q <= '{phase: tcic_pkg::RC_IDLE, ms_cnt: 10'h000, done: 1'b0};
        end else if (ce_i) begin
            s_q <= s_d;
        end
    end

    // Outputs decode straight from the registered state.
    assign busy_o = (s_q.phase != tcic_pkg::RC_IDLE);
    assign analog_o = (s_q.phase == tcic_pkg::RC_ANALOG);
    assign digital_o = (s_q.phase == tcic_pkg::RC_DIGITAL);
    assign done_o = s_q.done;

endmodule // tcic_recal_seq

// ### dv/tcic_monitor.sv
/* Port checker of the touch calibration and interrupt register bank.
   Assumes the one clock and active-high reset of tcic_top, bound at the foot of this file. */
`timescale 1ns/1ps
module tcic_monitor #(
    parameter int unsigned CYCLES_PER_MS = 4
) (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic ce_i,
    // Register port.
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    // Touch, slide and status inputs.
    input wire logic [13:0] touch_raw_i,
    input wire logic slide_active_i,
    input wire logic group_event_status_i,
    input wire logic [6:0] sensor_status_i,
    input wire logic [7:0] gpio_status_i,
    // Results.
    input wire logic [13:0] touch_valid_o,
    input wire logic [13:0] base_invalid_o,
    input wire logic [13:0] analog_cal_o,
    input wire logic [13:0] digital_cal_o,
    input wire logic slide_repeat_tick_o,
    input wire logic irq_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Inputs touched while busy; each must be idle one edge later.
    logic [13:0] abort_q;
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            abort_q <= '0;
        end else begin
            abort_q <= ce_i ? (touch_raw_i & base_invalid_o) : '0;
        end
    end

    AST_TOUCH_MASK: assert property (touch_valid_o == (touch_raw_i & ~base_invalid_o))
        else $error("touch seen on a recalibrating input");
    AST_PHASE_SPLIT: assert property ((analog_cal_o & digital_cal_o) == '0 &&
        base_invalid_o == (analog_cal_o | digital_cal_o)) else $error("phase outputs disagree");
    AST_ANALOG_FIRST: assert property ((digital_cal_o & ~$past(digital_cal_o) & ~$past(analog_cal_o)) == '0)
        else $error("base capture began without analog trim");
    AST_TOUCH_ABORT: assert property ((base_invalid_o & abort_q) == '0)
        else $error("recalibration survived a touch");
    AST_IRQ_QUIET: assert property (ce_i && !group_event_status_i && sensor_status_i == '0 &&
        gpio_status_i == '0 |=> !irq_o) else $error("interrupt without status");
    AST_READBACK: assert property ((ce_i && reg_wr_i && reg_addr_i == 8'h24) ##1
        (ce_i && reg_rd_i && !reg_wr_i && reg_addr_i == 8'h24) |=> reg_rdata_o == $past(reg_wdata_i, 2))
        else $error("timing register readback wrong");
    AST_UNUSED_BIT: assert property (ce_i && reg_rd_i && reg_addr_i == 8'h46 |=> !reg_rdata_o[7])
        else $error("unused grouped force bit read as one");
    AST_TICK_PULSE: assert property (slide_repeat_tick_o |-> $past(slide_active_i) ##1 !slide_repeat_tick_o)
        else $error("slide tick outside a slide or too long");

    COV_ANALOG: cover property ($rose(analog_cal_o[0]));
    COV_DIGITAL: cover property ($rose(digital_cal_o[13]));
    COV_IRQ: cover property ($rose(irq_o));
    COV_TICK: cover property (slide_repeat_tick_o);
endmodule // tcic_monitor

bind tcic_top tcic_monitor #(.CYCLES_PER_MS(CYCLES_PER_MS)) u_mon (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o),
    .touch_raw_i(touch_raw_i),
    .slide_active_i(slide_active_i),
    .group_event_status_i(group_event_status_i),
    .sensor_status_i(sensor_status_i),
    .gpio_status_i(gpio_status_i),
    .touch_valid_o(touch_valid_o),
    .base_invalid_o(base_invalid_o),
    .analog_cal_o(analog_cal_o),
    .digital_cal_o(digital_cal_o),
    .slide_repeat_tick_o(slide_repeat_tick_o),
    .irq_o(irq_o)
);

// ### dv/tcic_host_model.sv
/* Host side of the register port: writes and reads one byte per call.
   Assumes every call starts just after a falling clock edge. */
`timescale 1ns/1ps
module tcic_host_model (
    // Clock and read data.
    input wire logic sys_clk_i,
    input wire logic [7:0] reg_rdata_i,
    // Requests toward the block.
    output logic reg_wr_o,
    output logic reg_rd_o,
    output logic [7:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    // Idle strobes from time zero.
    initial begin
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'h00;
        reg_wdata_o = 8'h00;
    end

    // An idle edge first, then a strobe across exactly one rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(negedge sys_clk_i);
        reg_addr_o = a;
        reg_wdata_o = v;
        reg_wr_o = 1'b1;
        @(negedge sys_clk_i);
        reg_wr_o = 1'b0;
    endtask

    // Data is taken a full cycle after the strobe, where it stands until the next read.
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge sys_clk_i);
        reg_rd_o = 1'b0;
        @(negedge sys_clk_i);
        v = reg_rdata_i;
    endtask
endmodule // tcic_host_model

// ### dv/tcic_top_tb.sv
/* Self-checking bench of the touch calibration and interrupt register bank.
   Assumes four clocks per millisecond, so a full recalibration lasts 2400 clocks. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fails++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
`define WAITFOR(c, n) for (wk = 0; wk < (n) && !(c); wk++) @(negedge sys_clk_i);
module tcic_top_tb;
    // Clock, reset, counters and scratch.
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic ce_i = 1'b1;
    int fails = 0;
    int samples_checked = 0;
    int wk;
    int cycles = 0;
    logic [7:0] d;
    // Block inputs.
    logic reg_wr_i, reg_rd_i;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic [6:0] sample_en_i = 7'h7f;
    logic [13:0] touch_raw_i = '0;
    logic [13:0] drift_recal_req_i = '0;
    logic slide_active_i = 1'b0;
    logic [1:0] slide_speed_i = 2'h0;
    logic [15:0] st = '0;
    // Block outputs.
    logic [13:0] touch_valid_o, base_invalid_o, analog_cal_o, digital_cal_o;
    logic slide_repeat_tick_o, irq_o;
    // Offsets with reset values; the last offset is unmapped.
    logic [7:0] at [7] = '{8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h46, 8'h29};
    logic [7:0] rt [7] = '{8'hd4, 8'hff, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};

    tcic_host_model u_host (.sys_clk_i(sys_clk_i), .reg_rdata_i(reg_rdata_o), .reg_wr_o(reg_wr_i),
        .reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i), .reg_wdata_o(reg_wdata_i));
    tcic_top #(.CYCLES_PER_MS(4)) u_dut (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o), .sample_en_i(sample_en_i), .touch_raw_i(touch_raw_i),
        .drift_recal_req_i(drift_recal_req_i), .slide_active_i(slide_active_i), .slide_speed_i(slide_speed_i),
        .group_event_status_i(st[15]), .sensor_status_i(st[14:8]), .gpio_status_i(st[7:0]),
        .touch_valid_o(touch_valid_o), .base_invalid_o(base_invalid_o), .analog_cal_o(analog_cal_o),
        .digital_cal_o(digital_cal_o), .slide_repeat_tick_o(slide_repeat_tick_o), .irq_o(irq_o));

    // Clock of 5 ns period.
    initial begin
        forever #2.5 sys_clk_i = ~sys_clk_i;
    end

    // Hang guard: the tests need about 15000 clocks.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 40000) begin
            fails++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checked %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Forced run on one input; an optional touch in the trim phase must abort it but keep the bit.
    task automatic recal(input logic [7:0] a, input logic [7:0] v, input int ch, input bit ab);
        u_host.wr(a, v);
        `WAITFOR(analog_cal_o[ch], 4)
        if (ab) begin
            touch_raw_i[ch] = 1'b1;
            #1 `CHK(touch_valid_o[ch], 1'b0)
            @(negedge sys_clk_i);
            `CHK(base_invalid_o[ch], 1'b0)
            u_host.rd(a, d);
            `CHK(d & v, v)
            touch_raw_i[ch] = 1'b0;
            `WAITFOR(analog_cal_o[ch], 8)
        end
        `CHK(base_invalid_o[ch], 1'b1)
        `WAITFOR(digital_cal_o[ch], 500)
        `CHK(wk inside {[390:410]}, 1'b1)
        `WAITFOR(!base_invalid_o[ch], 2100)
        `CHK(wk inside {[1990:2010]}, 1'b1)
        repeat (2) @(negedge sys_clk_i);
        u_host.rd(a, d);
        `CHK(d & v, 8'h00)
    endtask

    // Automatic request on one input under a given enable setting.
    task automatic auto(input int ch, input logic [7:0] cfg, input logic [6:0] se, input logic ex);
        u_host.wr(8'h25, cfg);
        sample_en_i = se;
        drift_recal_req_i[ch] = 1'b1;
        repeat (4) @(negedge sys_clk_i);
        `CHK(analog_cal_o[ch], ex)
        drift_recal_req_i[ch] = 1'b0;
        `WAITFOR(base_invalid_o == '0, 2500)
    endtask

    // Spacing of two slide ticks after a speed change.
    task automatic slide(input logic [1:0] sp, input int lo, input int hi);
        slide_speed_i = sp;
        slide_active_i = 1'b1;
        `WAITFOR(slide_repeat_tick_o, 700)
        @(negedge sys_clk_i);
        `WAITFOR(slide_repeat_tick_o, 700)
        `CHK(wk inside {[lo:hi]}, 1'b1)
    endtask

    initial begin
        repeat (12) @(negedge sys_clk_i);
        sys_rst_i = 1'b0;
        @(negedge sys_clk_i);
        for (int i = 0; i < 7; i++) begin
            u_host.rd(at[i], d);
            `CHK(d, rt[i])
        end
        u_host.wr(8'h24, 8'h15);
        u_host.rd(8'h24, d);
        `CHK(d, 8'h15)
        u_host.wr(8'h46, 8'hff);
        u_host.rd(8'h46, d);
        `CHK(d, 8'h7f)
        u_host.wr(8'h46, 8'h00);
        // Every status bit alone, first with all enables on, then all off.
        u_host.wr(8'h28, 8'hff);
        for (int e = 0; e < 2; e++) begin
            for (int i = 0; i < 16; i++) begin
                st = 16'h0001 << i;
                repeat (2) @(negedge sys_clk_i);
                `CHK(irq_o, e == 0)
            end
            st = '0;
            u_host.wr(8'h27, 8'h00);
            u_host.wr(8'h28, 8'h00);
        end
        recal(8'h26, 8'h01, 0, 1'b1);
        recal(8'h46, 8'h40, 13, 1'b0);
        // Group force with one grouped input held off by a touch.
        u_host.wr(8'h26, 8'h80);
        `WAITFOR(analog_cal_o[13:7] == 7'h7f, 4)
        `CHK(analog_cal_o[13:7], 7'h7f)
        touch_raw_i[7] = 1'b1;
        repeat (200) @(negedge sys_clk_i);
        touch_raw_i[7] = 1'b0;
        `WAITFOR(base_invalid_o[13:8] == '0, 2500)
        u_host.rd(8'h26, d);
        `CHK(d, 8'h80)
        `WAITFOR(base_invalid_o == '0, 2500)
        repeat (2) @(negedge sys_clk_i);
        u_host.rd(8'h26, d);
        `CHK(d, 8'h00)
        auto(0, 8'hff, 7'h7e, 1'b0);
        auto(0, 8'hfe, 7'h7f, 1'b0);
        auto(0, 8'hff, 7'h7f, 1'b1);
        auto(7, 8'h7f, 7'h7f, 1'b0);
        auto(7, 8'hff, 7'h7f, 1'b1);
        u_host.wr(8'h24, 8'h00);
        slide(2'h0, 134, 142);
        slide(2'h1, 62, 70);
        // A grouped press past the 560 ms limit recalibrates the group.
        touch_raw_i[7] = 1'b1;
        `WAITFOR(analog_cal_o[8], 2300)
        `CHK(wk inside {[2230:2250]}, 1'b1)
        tally_and_finish();
    end
endmodule // tcic_top_tb
